// *** common/autoload_pkg.sv ***
// Package: word addresses, field positions, defaults and types for autoload
package autoload_pkg;
   localparam logic [7:0]  ADDR_DETECT     = 8'h23;
   localparam logic [7:0]  ADDR_REV_A      = 8'h27;
   localparam logic [7:0]  ADDR_REV_B      = 8'h28;
   localparam logic [7:0]  ADDR_SETUP      = 8'h29;
   localparam logic [7:0]  ADDR_FINFO      = 8'h2B;
   localparam int          DET_CKSUM_BIT   = 15;
   localparam int          SET_MSI_BIT     = 15;
   localparam int          SET_NMI_BIT     = 13;
   localparam int          SET_PULL_BIT    = 12;
   localparam int          SET_P1_BIT      = 9;
   localparam int          SET_P0_BIT      = 8;
   localparam int          FI_ROM_LSB      = 8;
   localparam int          FI_PF_LSB       = 3;
   localparam int          FI_SWFA_BIT     = 2;
   localparam int          FI_MAP_BIT      = 1;
   localparam logic [7:0]  KEY_THIRD       = 8'h3D;
   localparam logic [7:0]  KEY_SECOND      = 8'h2D;
   localparam logic [7:0]  KEY_FIRST       = 8'h1D;
   localparam logic [3:0]  ROM_CODE_MAX    = 4'h8;
   localparam logic [3:0]  PF_CODE_MAX     = 4'h7;
   localparam logic [23:0] CLASS_STORAGE   = 24'h01_0000;
   localparam logic [23:0] CLASS_NETWORK   = 24'h02_0000;
   // Reset value of the MSI, NMI, pull-up and flash access default fields before loading
   localparam logic        DEF_MSI         = 1'b1;
   localparam logic        DEF_NMI         = 1'b1;
   localparam logic        DEF_PULL        = 1'b1;
   localparam logic        DEF_SWFA        = 1'b1;
   // Revision identifier default (arbitrary value)
   localparam logic [7:0]  DEF_REVISION_IDENTIFIER_REG      = 8'h01;

   typedef enum logic [2:0] {
      ST_DETECT, ST_REV_A, ST_REV_B, ST_SETUP, ST_FINFO, ST_DONE
   } load_state_t;

   typedef struct packed {
      logic        cksum_valid;
      logic [7:0]  rev_override_first;
      logic [7:0]  rev_override_second;
      logic [7:0]  rev_override_third;
      logic        msi_capability_enable;
      logic        nmi_route_enable;
      logic        software_definable_pins_pullup;
      logic [23:0] class_port0;
      logic [23:0] class_port1;
      logic [4:0]  rom_size_log2_kb;
      logic [4:0]  pflash_size_log2_kb;
      logic        software_flash_access_default;
      logic        flash_map_parallel;
   } cfg_t;
endpackage

// *** hw/nvm_autoload_config.sv ***
// Autoload of configuration words from NVM and revision key override
`timescale 1ns/1ns
// Summary of operation
// - Bit 15 of word 23h is captured as the checksum-verified flag.
// - A revision key 3Dh, 2Dh or 1Dh returns the third, second or first byte.
// - Word 29h is loaded and its fields drive internal settings.
// - Bit 15 of word 29h sets the MSI capability declaration, default on.
// - Bit 13 of word 29h allows IOCHK interrupts over the serial line.
// - Bit 12 of word 29h holds the general pins pulled up until released.
// - Bit 9 of word 29h picks storage or network class for the second port.
// - Bit 8 of word 29h picks storage or network class for the first port.
// - Word 2Bh is loaded and its sizing and access fields are applied.
// - Bits 11 to 8 of word 2Bh size the expansion ROM, 64 KB to 16 MB.
// - Bits 6 to 3 of word 2Bh size the parallel flash, 64 KB to 8 MB.
// - Bit 2 of word 2Bh is the reset default of flash access bit 7.
// - Bit 1 of word 2Bh selects serial or parallel mapped flash.
module nvm_autoload_config
   import autoload_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   output logic             rd_req_o,
   output logic [7:0]       rd_addr_o,
   input  wire logic        rd_ack_i,
   input  wire logic [15:0] rd_data_i,
   input  wire logic        rev_key_we_i,
   input  wire logic [7:0]  rev_key_i,
   input  wire logic        pullup_release_i,
   output logic [7:0]       revision_identifier_reg_o,
   output cfg_t             cfg_o,
   output logic             pins_pullup_o,
   output logic             cfg_ready_o
);
   typedef struct packed {
      load_state_t st;
      cfg_t        cfg;
      logic [7:0]  key;
      logic        pull;
      logic [7:0]  rev;
      logic [7:0]  addr;
   } state_t;

   state_t     s_r;
   state_t     s_nxt;
   logic [4:0] rom_l2;
   logic [4:0] pf_l2;

   size_decode #(.MAX_CODE(ROM_CODE_MAX)) u_rom (
      .code_i    (rd_data_i[FI_ROM_LSB +: 4]),
      .log2_kb_o (rom_l2)
   );
   size_decode #(.MAX_CODE(PF_CODE_MAX)) u_pf (
      .code_i    (rd_data_i[FI_PF_LSB +: 4]),
      .log2_kb_o (pf_l2)
   );

   always_comb begin
      s_nxt = s_r;
      if (rev_key_we_i) begin
         s_nxt.key = rev_key_i;
      end
      if (pullup_release_i) begin
         s_nxt.pull = 1'b0;
      end
      case (s_r.st)
         ST_DETECT: begin
            if (rd_ack_i) begin
               s_nxt.cfg.cksum_valid = rd_data_i[DET_CKSUM_BIT];
               s_nxt.st = ST_REV_A;
            end
         end
         ST_REV_A: begin
            if (rd_ack_i) begin
               s_nxt.cfg.rev_override_third  = rd_data_i[15:8];
               s_nxt.cfg.rev_override_second = rd_data_i[7:0];
               s_nxt.st = ST_REV_B;
            end
         end
         ST_REV_B: begin
            if (rd_ack_i) begin
               s_nxt.cfg.rev_override_first = rd_data_i[15:8];
               s_nxt.st = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (rd_ack_i) begin
               s_nxt.cfg.msi_capability_enable =
                  rd_data_i[SET_MSI_BIT];
               s_nxt.cfg.nmi_route_enable = rd_data_i[SET_NMI_BIT];
               s_nxt.cfg.software_definable_pins_pullup =
                  rd_data_i[SET_PULL_BIT];
               s_nxt.pull = rd_data_i[SET_PULL_BIT];
               s_nxt.cfg.class_port1 = rd_data_i[SET_P1_BIT] ?
                  CLASS_STORAGE : CLASS_NETWORK;
               s_nxt.cfg.class_port0 = rd_data_i[SET_P0_BIT] ?
                  CLASS_STORAGE : CLASS_NETWORK;
               s_nxt.st = ST_FINFO;
            end
         end
         ST_FINFO: begin
            if (rd_ack_i) begin
               s_nxt.cfg.rom_size_log2_kb    = rom_l2;
               s_nxt.cfg.pflash_size_log2_kb = pf_l2;
               s_nxt.cfg.software_flash_access_default =
                  rd_data_i[FI_SWFA_BIT];
               s_nxt.cfg.flash_map_parallel = rd_data_i[FI_MAP_BIT];
               s_nxt.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_nxt.st = ST_DONE;
         end
         default: begin
            s_nxt.st = ST_DETECT;
         end
      endcase
      // Revision value chosen by last written key
      case (s_nxt.key)
         KEY_THIRD:  s_nxt.rev = s_nxt.cfg.rev_override_third;
         KEY_SECOND: s_nxt.rev = s_nxt.cfg.rev_override_second;
         KEY_FIRST:  s_nxt.rev = s_nxt.cfg.rev_override_first;
         default:    s_nxt.rev = DEF_REVISION_IDENTIFIER_REG;
      endcase
      // Word address per load step
      case (s_nxt.st)
         ST_DETECT: s_nxt.addr = ADDR_DETECT;
         ST_REV_A:  s_nxt.addr = ADDR_REV_A;
         ST_REV_B:  s_nxt.addr = ADDR_REV_B;
         ST_SETUP:  s_nxt.addr = ADDR_SETUP;
         ST_FINFO:  s_nxt.addr = ADDR_FINFO;
         default:   s_nxt.addr = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r.st   <= ST_DETECT;
         s_r.key  <= 8'h00;
         s_r.pull <= DEF_PULL;
         s_r.rev  <= DEF_REVISION_IDENTIFIER_REG;
         s_r.addr <= ADDR_DETECT;
         s_r.cfg  <= '{cksum_valid: 1'b0,
                       rev_override_first: 8'h00,
                       rev_override_second: 8'h00,
                       rev_override_third: 8'h00,
                       msi_capability_enable: DEF_MSI,
                       nmi_route_enable: DEF_NMI,
                       software_definable_pins_pullup: DEF_PULL,
                       class_port0: CLASS_NETWORK,
                       class_port1: CLASS_NETWORK,
                       rom_size_log2_kb: 5'd6,
                       pflash_size_log2_kb: 5'd6,
                       software_flash_access_default: DEF_SWFA,
                       flash_map_parallel: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_addr_o     = s_r.addr;
   assign rd_req_o      = (s_r.st != ST_DONE);
   assign cfg_ready_o   = (s_r.st == ST_DONE);
   assign cfg_o         = s_r.cfg;
   assign pins_pullup_o = s_r.pull;

   assign revision_identifier_reg_o = s_r.rev;

   a_ready_after_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_FINFO && rd_ack_i) |=> cfg_ready_o)
      else $error("ready not raised after last word");
   a_ready_stays: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_ready_o |=> cfg_ready_o)
      else $error("ready dropped");
   a_cksum_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_DETECT && rd_ack_i) |=>
      cfg_o.cksum_valid == $past(rd_data_i[15]))
      else $error("checksum flag wrong");
   a_key_third: assert property (@(posedge clk_i) disable iff (rst_i)
      (rev_key_we_i && rev_key_i == 8'h3D) |=>
      revision_identifier_reg_o == cfg_o.rev_override_third)
      else $error("third override not returned");
   a_key_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (rev_key_we_i && rev_key_i == 8'h1D) |=>
      revision_identifier_reg_o == cfg_o.rev_override_first)
      else $error("first override not returned");
   a_msi_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_SETUP && rd_ack_i) |=>
      cfg_o.msi_capability_enable == $past(rd_data_i[15]))
      else $error("msi bit not applied");
   a_nmi_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_SETUP && rd_ack_i) |=>
      cfg_o.nmi_route_enable == $past(rd_data_i[13]))
      else $error("nmi bit not applied");
   a_pull_release: assert property (@(posedge clk_i) disable iff (rst_i)
      (pullup_release_i && !(s_r.st == ST_SETUP && rd_ack_i)) |=>
      !pins_pullup_o)
      else $error("pull-ups not released");
   a_class_port1: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_SETUP && rd_ack_i && rd_data_i[9]) |=>
      cfg_o.class_port1 == 24'h01_0000)
      else $error("port1 class wrong");
   a_class_port0: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_SETUP && rd_ack_i && !rd_data_i[8]) |=>
      cfg_o.class_port0 == 24'h02_0000)
      else $error("port0 class wrong");
   a_rom_bad_code: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_FINFO && rd_ack_i && rd_data_i[11:8] > 4'h8) |=>
      cfg_o.rom_size_log2_kb == 5'd6)
      else $error("rom size fallback wrong");
   a_pf_max: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_FINFO && rd_ack_i && rd_data_i[6:3] == 4'h7) |=>
      cfg_o.pflash_size_log2_kb == 5'd13)
      else $error("pflash 8 MB wrong");
   a_swfa_map: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == ST_FINFO && rd_ack_i) |=>
      cfg_o.software_flash_access_default == $past(rd_data_i[2]) &&
      cfg_o.flash_map_parallel == $past(rd_data_i[1]))
      else $error("flash access fields wrong");
endmodule

// *** hw/size_decode.sv ***
// Size code to log2 of kilobytes, out-of-range codes fall back to 64 KB
`timescale 1ns/1ns
module size_decode
   import autoload_pkg::*;
#(
   parameter logic [3:0] MAX_CODE = 4'h8
) (
   input  wire logic [3:0] code_i,
   output logic      [4:0] log2_kb_o
);
   // 0000b is 64 KB (2^6 KB), each step doubles
   always_comb begin
      if (code_i <= MAX_CODE) begin
         log2_kb_o = 5'd6 + {1'b0, code_i};
      end else begin
         log2_kb_o = 5'd6;
      end
   end
endmodule

// *** sim/nvm_autoload_config_test.sv ***
// Self-checking bench for the autoload block with random images
`timescale 1ns/1ns
module nvm_autoload_config_test;
   import autoload_pkg::*;
   logic             clk, rst, rd_req, rd_ack, key_we, rel, pull, ready;
   logic [7:0]       rd_addr, key, rev;
   logic [15:0]      rd_data;
   logic [3:0]       delay;
   logic [4:0][15:0] img;
   cfg_t             cfg;
   int               mismatches, check_count, it, k, n, j;
   logic [7:0]       keys [4];
   logic [7:0]       revs [4];
   logic [7:0]       addrs [5] = '{8'h23, 8'h27, 8'h28, 8'h29, 8'h2B};
   always #10 clk = ~clk;
   nvm_autoload_config nvm_autoload_config_i (.clk_i(clk), .rst_i(rst),
      .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack),
      .rd_data_i(rd_data), .rev_key_we_i(key_we), .rev_key_i(key),
      .pullup_release_i(rel), .revision_identifier_reg_o(rev),
      .cfg_o(cfg), .pins_pullup_o(pull), .cfg_ready_o(ready));
   nvm_model nvm_model_i (.clk_i(clk), .rst_i(rst), .rd_req_i(rd_req),
      .rd_addr_i(rd_addr), .delay_i(delay), .img_i(img),
      .rd_ack_o(rd_ack), .rd_data_o(rd_data));
   function automatic logic [4:0] sz(input logic [3:0] c,
                                     input logic [3:0] mx);
      return (c <= mx) ? 5'h06 + {1'b0, c} : 5'h06;
   endfunction
   function automatic logic [23:0] cls(input logic b);
      return b ? CLASS_STORAGE : CLASS_NETWORK;
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
   endtask
   // Random image with the reserved fields as the writer must set them
   task automatic mk_img;
      img[0] = {1'($urandom), 15'h7FFF};
      img[1] = 16'($urandom);
      img[2] = 16'($urandom);
      img[3] = (16'($urandom) & 16'hB300) | 16'h0085;
      img[4] = 16'($urandom) & 16'h0F7E;
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      key_we = 1'b0;
      key = 8'h00;
      rel = 1'b0;
      img = '0;
      delay = 4'h0;
      mismatches = 0;
      check_count = 0;
      k = $urandom(92);
      repeat (8) @(posedge clk);
      chk({cfg.msi_capability_enable, cfg.nmi_route_enable, pull}, 3'h7);
      chk({cfg.software_flash_access_default, ready}, 2'h2);
      chk(cfg.class_port0, CLASS_NETWORK);
      chk(cfg.rom_size_log2_kb, 5'h06);
      chk(cfg.pflash_size_log2_kb, 5'h06);
      chk(cfg.class_port1, CLASS_NETWORK);
      chk({cfg.cksum_valid, cfg.flash_map_parallel}, 2'h0);
      chk(cfg.software_definable_pins_pullup, DEF_PULL);
      chk(rev, DEF_REVISION_IDENTIFIER_REG);
      for (it = 0; it < 6; it++) begin
         mk_img;
         if (it < 2) begin
            img[4][11:8] = 4'h8 + 4'(it);
            img[4][6:3]  = 4'h7 + 4'(it);
         end
         delay = 4'(it * 3 % 8);
         do_reset;
         if (it == 2) begin
            repeat (3) @(negedge clk);
            mk_img;
            do_reset;
         end
         n = 0;
         k = 0;
         while (ready !== 1'b1 && k < 200) begin
            @(negedge clk);
            if (rd_ack === 1'b1 && rd_req === 1'b1 && n < 5) begin
               chk(rd_addr, addrs[n]);
               n++;
            end
            k++;
         end
         if (ready !== 1'b1) begin
            mismatches++;
            break;
         end
         chk(8'(n), 8'h05);
         chk(rd_req, 1'b0);
         chk(cfg.cksum_valid, img[0][15]);
         chk(cfg.msi_capability_enable, img[3][15]);
         chk(cfg.nmi_route_enable, img[3][13]);
         chk(pull, img[3][12]);
         chk(cfg.software_definable_pins_pullup, img[3][12]);
         chk(rd_addr, 8'h00);
         chk(cfg.class_port1, cls(img[3][9]));
         chk(cfg.class_port0, cls(img[3][8]));
         chk(cfg.rom_size_log2_kb, sz(img[4][11:8], ROM_CODE_MAX));
         chk(cfg.pflash_size_log2_kb, sz(img[4][6:3], PF_CODE_MAX));
         chk(cfg.software_flash_access_default, img[4][2]);
         chk(cfg.flash_map_parallel, img[4][1]);
         keys = '{KEY_THIRD, KEY_SECOND, KEY_FIRST, 8'($urandom) | 8'h40};
         revs = '{img[1][15:8], img[1][7:0], img[2][15:8], DEF_REVISION_IDENTIFIER_REG};
         for (j = 0; j < 4; j++) begin
            @(posedge clk);
            key_we <= 1'b1;
            key    <= keys[j];
            @(posedge clk);
            key_we <= 1'b0;
            @(negedge clk);
            chk(rev, revs[j]);
         end
         @(posedge clk);
         rel <= 1'b1;
         @(posedge clk);
         rel <= 1'b0;
         @(negedge clk);
         chk(pull, 1'b0);
         $display("test %0d done", it);
      end
      close_out;
   end
endmodule

// *** sim/nvm_model.sv ***
// Partner model: NVM answering word reads from an image
`timescale 1ns/1ns
module nvm_model (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             rd_req_i,
   input  wire logic [7:0]       rd_addr_i,
   input  wire logic [3:0]       delay_i,
   input  wire logic [4:0][15:0] img_i,
   output logic                  rd_ack_o,
   output logic      [15:0]      rd_data_o
);
   logic [3:0]  wait_r;
   logic [15:0] word;
   // Image words; the bench builds them with the reserved patterns
   always_comb begin
      case (rd_addr_i)
         8'h23:   word = img_i[0];
         8'h27:   word = img_i[1];
         8'h28:   word = img_i[2];
         8'h29:   word = img_i[3];
         8'h2B:   word = img_i[4];
         default: word = ~rd_data_o;
      endcase
   end
   // Ack after a programmable wait; data toggles when not valid
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ack_o  <= 1'b0;
         rd_data_o <= 16'h0000;
         wait_r    <= 4'h0;
      end else if (rd_req_i && !rd_ack_o && wait_r >= delay_i) begin
         rd_ack_o  <= 1'b1;
         rd_data_o <= word;
         wait_r    <= 4'h0;
      end else begin
         rd_ack_o  <= 1'b0;
         rd_data_o <= ~rd_data_o;
         wait_r    <= (rd_req_i && !rd_ack_o) ? wait_r + 4'h1 : 4'h0;
      end
   end
endmodule
